/* File: src/flash_boot_mux_regs.vh */
// Purpose: constants for the shared flash boot and mux control block
// Assumes: 100 MHz core clock
// Notes: definitions only
`ifndef FLASH_BOOT_MUX_REGS_VH
`define FLASH_BOOT_MUX_REGS_VH
`define STAT_ADDR_PORT0 7'h38
`define STAT_ADDR_PORT1 7'h3f
`define CLK_PERIOD_NS 10
`define SUPPLY_SETTLE_US 100
`define SUPPLY_SETTLE_CYC ((`SUPPLY_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: src/shared_flash_boot_mux_ctrl.v */
// Purpose: shared flash boot sequencing, link controller reset, status target, mux lines
// Assumes: inputs synchronous to i_ref_clk; serial engines for flash and i2c live outside
// Notes: one-hot boot state machine; flash grant goes to the link controller only after config load
// Functional notes
// (R1) own configuration read from shared flash before link controller may fetch firmware
// (R2) link controller reset held while own configuration read is in progress
// (R3) one dedicated output is the active-low link controller reset, nothing else
// (R4) board gating releases link reset at least 100 us after its supply is good
// (R5) board ANDs reset output with link controller supply good
// (R6) embedded controller may instead release reset after system boot
// (R7) port 0 status at address 0x38, port 1 status at 0x3f
// (R8) secondary target port answers both addresses on the same bus
// (R9) on connection, assert interrupt and offer that port's data status
// (R10) link controller ties both interrupt inputs to ours and polls both addresses
// (R11) sbu selects from port 0 orientation, enables from dp mode and tunnel events
// (R12) ss flip from orientation, usb line from usb3 event, dp line from dp mode
// (R13) initiator port configures system-on-chip mux functions
// (R14) embedded controller reaches us through the target-only secondary port
// (R15) mux outputs registered, glitch-free, held until next event
`timescale 1ns/1ns
`include "flash_boot_mux_regs.vh"
`default_nettype none
module shared_flash_boot_mux_ctrl #(
    parameter SETTLE_CYC = `SUPPLY_SETTLE_CYC,
    parameter STATUS_W = 8
)(
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // flash configuration loader
    output wire o_cfg_load_start,
    input wire i_cfg_load_done,
    output wire o_flash_grant_link,
    // link controller reset
    input wire i_ec_hold_link_reset,
    input wire i_link_ctrl_supply_good,
    output wire o_link_ctrl_reset_line_n,
    // secondary target port lookup
    input wire i_tgt_addr_valid,
    input wire [6:0] i_tgt_addr,
    input wire i_tgt_status_read,
    output wire o_tgt_addr_ack,
    output wire [STATUS_W-1:0] o_tgt_rdata,
    output wire o_tgt_int_n,
    // port state
    input wire [1:0] i_port_connected,
    input wire [STATUS_W-1:0] i_port0_status,
    input wire [STATUS_W-1:0] i_port1_status,
    input wire i_orientation,
    input wire i_usb3_event,
    input wire i_dp_mode,
    input wire i_tunnel_mode,
    // initiator port request for soc mux setup
    input wire i_init_busy,
    output wire o_init_req,
    output wire [2:0] o_init_mux_cfg,
    // mux and re-driver lines
    output wire o_sbu_sel_a,
    output wire o_sbu_sel_b,
    output wire o_sbu_en_aux,
    output wire o_sbu_en_sideband,
    output wire o_ss_flip,
    output wire o_ss_ctrl_usb,
    output wire o_ss_ctrl_dp
);
    // one-hot boot states
    localparam ST_IDLE = 4'h1;
    localparam ST_CFG = 4'h2;
    localparam ST_HOLD = 4'h4;
    localparam ST_RUN = 4'h8;
    localparam CW = 24;
    reg [3:0] state;
    reg [3:0] next_state;
    reg cfg_start;
    reg reset_n;
    reg [CW-1:0] settle_cnt;
    reg [1:0] conn_prev;
    reg [1:0] pending;
    reg ack;
    reg [STATUS_W-1:0] rdata;
    reg [6:0] mux_q;
    reg [2:0] init_cfg;
    reg init_req;
    wire hit0;
    wire hit1;
    wire [1:0] conn_rise;
    wire [1:0] clr;
    wire [2:0] soc_mux_cfg;

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                next_state = ST_CFG;
            end
            ST_CFG:
            begin
                // flash stays ours until the whole configuration is in
                if (i_cfg_load_done)
                    next_state = ST_HOLD; // (R1)
            end
            ST_HOLD:
            begin
                if (settle_cnt >= SETTLE_CYC[CW-1:0])
                    next_state = ST_RUN;
            end
            ST_RUN:
            begin
                next_state = ST_RUN;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_ref_clk)
    begin
        if (i_rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // one pulse per reset, so the loader is never restarted behind the link controller
    always @(posedge i_ref_clk)
    begin
        if (i_rst)
            cfg_start <= 1'b0;
        else
            cfg_start <= (state == ST_IDLE); // (R1)
    end

    // settle count is belt and braces; board gating still owns the supply timing
    always @(posedge i_ref_clk)
    begin
        if (i_rst)
            settle_cnt <= {CW{1'b0}};
        else if (state == ST_HOLD && i_link_ctrl_supply_good)
            settle_cnt <= settle_cnt + 1'b1; // (R4)
        else if (state == ST_HOLD)
            settle_cnt <= {CW{1'b0}};
    end

    // a supply drop in run pulls reset on the next clock edge, and its return releases it with no fresh settle wait
    always @(posedge i_ref_clk)
    begin
        if (i_rst)
            reset_n <= 1'b0;
        else
            reset_n <= (state == ST_RUN) && !i_ec_hold_link_reset && i_link_ctrl_supply_good; // (R2) (R5) (R6)
    end

    assign o_cfg_load_start = cfg_start;
    assign o_flash_grant_link = (state == ST_RUN); // (R1)
    assign o_link_ctrl_reset_line_n = reset_n; // (R3)

    assign hit0 = (i_tgt_addr == `STAT_ADDR_PORT0); // (R7)
    assign hit1 = (i_tgt_addr == `STAT_ADDR_PORT1); // (R7)
    assign conn_rise = i_port_connected & ~conn_prev;
    assign clr = {2{i_tgt_status_read}} & {hit1, hit0};

    // a connect in the same cycle as a read keeps its pending bit
    always @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            conn_prev <= 2'b00;
            pending <= 2'b00;
            ack <= 1'b0;
            rdata <= {STATUS_W{1'b0}};
        end
        else
        begin
            conn_prev <= i_port_connected;
            pending <= conn_rise | (pending & ~clr); // (R9)
            ack <= i_tgt_addr_valid && (hit0 || hit1); // (R8) (R14)
            if (i_tgt_addr_valid && hit0)
                rdata <= i_port0_status; // (R9)
            else if (i_tgt_addr_valid && hit1)
                rdata <= i_port1_status;
        end
    end

    assign o_tgt_addr_ack = ack;
    assign o_tgt_rdata = rdata;
    assign o_tgt_int_n = ~(|pending); // (R9)

    assign soc_mux_cfg = {i_orientation, i_usb3_event, i_dp_mode};

    // registered lines: no decode glitch reaches the pins
    always @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            mux_q <= 7'h00;
            init_cfg <= 3'h0;
            init_req <= 1'b0;
        end
        else
        begin
            mux_q <= {i_orientation, i_orientation, i_dp_mode, i_tunnel_mode,
                      i_orientation, i_usb3_event, i_dp_mode}; // (R11) (R12) (R15)
            if (init_req && !i_init_busy)
                init_req <= 1'b0;
            if (soc_mux_cfg != init_cfg)
            begin
                init_cfg <= soc_mux_cfg; // (R13)
                init_req <= 1'b1;
            end
        end
    end

    assign o_sbu_sel_a = mux_q[6];
    assign o_sbu_sel_b = mux_q[5];
    assign o_sbu_en_aux = mux_q[4];
    assign o_sbu_en_sideband = mux_q[3];
    assign o_ss_flip = mux_q[2];
    assign o_ss_ctrl_usb = mux_q[1];
    assign o_ss_ctrl_dp = mux_q[0];
    assign o_init_req = init_req;
    assign o_init_mux_cfg = init_cfg;
endmodule // shared_flash_boot_mux_ctrl
`default_nettype wire

/* File: tb/fbm_checker.sv */
// Purpose: port checks for the boot and mux block
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none
module fbm_checker(
    // watched ports
    input wire logic i_ref_clk, i_rst, i_tgt_addr_valid, o_tgt_addr_ack, o_tgt_int_n,
    input wire logic [6:0] i_tgt_addr,
    input wire logic [1:0] i_port_connected,
    input wire logic o_flash_grant_link, o_link_ctrl_reset_line_n, i_link_ctrl_supply_good,
    input wire logic o_cfg_load_start, i_orientation, i_usb3_event, i_dp_mode, i_tunnel_mode,
    input wire logic o_sbu_sel_a, o_sbu_sel_b, o_sbu_en_aux, o_sbu_en_sideband,
    input wire logic o_ss_flip, o_ss_ctrl_usb, o_ss_ctrl_dp
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire hit = i_tgt_addr_valid && (i_tgt_addr == 7'h38 || i_tgt_addr == 7'h3f);
    sequence s_conn;
        $rose(i_port_connected[0]) || $rose(i_port_connected[1]);
    endsequence
    a_ack_hit: assert property (hit |=> o_tgt_addr_ack) else $error("no ack");
    a_ack_miss: assert property (!hit |=> !o_tgt_addr_ack) else $error("stray ack");
    a_boot_hold: assert property (!o_flash_grant_link |-> !o_link_ctrl_reset_line_n) else $error("early");
    a_supply_gate: assert property (!i_link_ctrl_supply_good |=> !o_link_ctrl_reset_line_n) else $error("gate");
    a_start_once: assert property (o_cfg_load_start |=> !o_cfg_load_start [*8]) else $error("restart");
    a_grant_kept: assert property (o_flash_grant_link |=> o_flash_grant_link) else $error("grant");
    a_int_conn: assert property (s_conn |-> ##[1:2] !o_tgt_int_n) else $error("no irq");
    a_sbu_lines: assert property (o_sbu_sel_a == $past(i_orientation) && o_sbu_sel_b == o_sbu_sel_a
        && o_sbu_en_aux == $past(i_dp_mode) && o_sbu_en_sideband == $past(i_tunnel_mode)) else $error("sbu");
    a_ss_lines: assert property (o_ss_flip == $past(i_orientation) && o_ss_ctrl_usb == $past(i_usb3_event)
        && o_ss_ctrl_dp == $past(i_dp_mode)) else $error("ss");
endmodule // fbm_checker
bind shared_flash_boot_mux_ctrl fbm_checker i_fbm_checker(.*);
`default_nettype wire

/* File: tb/link_side_model.sv */
// Purpose: flash loader and initiator engine beside the block
// Assumes: driven from the block's outputs
// Notes: initiator is slow, busy every other cycle
`timescale 1ns/1ns
`default_nettype none
module link_side_model #(parameter int DLY = 4)(
    input wire logic i_ref_clk, i_load_start, i_req,
    output logic o_load_done = 1'b0,
    output logic o_busy = 1'b0
);
    int cnt = -1;
    always @(posedge i_ref_clk)
    begin
        o_load_done <= (cnt == 0);
        cnt <= i_load_start ? DLY : (cnt >= 0 ? cnt - 1 : -1);
        o_busy <= i_req && !o_busy;
    end
endmodule // link_side_model
`default_nettype wire

/* File: tb/shared_flash_boot_mux_ctrl_tb.sv */
// Purpose: directed bench for the boot and mux block
// Assumes: inputs change at falling edge
// Notes: settle count shortened to 5
`timescale 1ns/1ns
`default_nettype none
module shared_flash_boot_mux_ctrl_tb;
    logic i_ref_clk = 0, i_rst = 1, i_ec_hold_link_reset = 0, i_link_ctrl_supply_good = 1, i_tgt_addr_valid = 0;
    logic i_tgt_status_read = 0, i_orientation = 0, i_usb3_event = 0, i_dp_mode = 0, i_tunnel_mode = 0;
    logic i_cfg_load_done, i_init_busy, o_cfg_load_start, o_flash_grant_link, o_link_ctrl_reset_line_n;
    logic o_tgt_addr_ack, o_tgt_int_n, o_init_req, o_sbu_sel_a, o_sbu_sel_b, o_sbu_en_aux;
    logic o_sbu_en_sideband, o_ss_flip, o_ss_ctrl_usb, o_ss_ctrl_dp;
    logic [6:0] i_tgt_addr = 0;
    logic [1:0] i_port_connected = 0;
    logic [7:0] i_port0_status = 8'h5a, i_port1_status = 8'hc3, o_tgt_rdata;
    logic [2:0] o_init_mux_cfg;
    int bad_count = 0, checks_done = 0, cyc = 0;
    shared_flash_boot_mux_ctrl #(.SETTLE_CYC(5)) i_shared_flash_boot_mux_ctrl(.*);
    link_side_model i_link_side_model(.i_ref_clk, .i_load_start(o_cfg_load_start), .i_req(o_init_req),
        .o_load_done(i_cfg_load_done), .o_busy(i_init_busy));
    task automatic chk(input logic [7:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc_n(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // valid left high so reads can run back to back
    task rd(input logic [6:0] a, input logic ak, input logic [7:0] d);
        i_tgt_addr = a;
        i_tgt_addr_valid = 1;
        cyc_n(1);
        chk(o_tgt_addr_ack, ak);
        if (ak)
            chk(o_tgt_rdata, d);
    endtask
    initial
        forever #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk)
        if (++cyc > 2000)
        begin
            bad_count++;
            print_verdict;
        end
    initial
    begin
        cyc_n(8);
        i_rst = 0;
        cyc_n(3);
        chk({o_link_ctrl_reset_line_n, o_flash_grant_link}, 0);
        cyc_n(20);
        chk({o_link_ctrl_reset_line_n, o_flash_grant_link}, 3);
        i_link_ctrl_supply_good = 0;
        cyc_n(2);
        chk(o_link_ctrl_reset_line_n, 0);
        i_link_ctrl_supply_good = 1;
        i_ec_hold_link_reset = 1;
        cyc_n(12);
        chk(o_link_ctrl_reset_line_n, 0);
        i_ec_hold_link_reset = 0;
        cyc_n(12);
        chk(o_link_ctrl_reset_line_n, 1);
        rd(7'h38, 1, 8'h5a);
        rd(7'h3f, 1, 8'hc3);
        rd(7'h39, 0, 0);
        rd(7'h38, 1, 8'h5a);
        chk(o_tgt_int_n, 1);
        i_port_connected = 2'b10;
        cyc_n(3);
        chk(o_tgt_int_n, 0);
        rd(7'h3f, 1, 8'hc3);
        i_tgt_status_read = 1;
        cyc_n(1);
        i_tgt_status_read = 0;
        i_tgt_addr_valid = 0;
        cyc_n(2);
        chk(o_tgt_int_n, 1);
        for (int i = 0; i < 16; i++)
        begin
            {i_orientation, i_usb3_event, i_dp_mode, i_tunnel_mode} = i[3:0];
            cyc_n(2);
            chk({o_sbu_sel_a, o_sbu_sel_b, o_sbu_en_aux, o_sbu_en_sideband}, {i[3], i[3], i[1], i[0]});
            chk({o_ss_flip, o_ss_ctrl_usb, o_ss_ctrl_dp}, i[3:1]);
        end
        cyc_n(8);
        chk({o_init_req, o_init_mux_cfg}, 7);
        {i_orientation, i_usb3_event, i_dp_mode, i_tunnel_mode} = 0;
        cyc_n(1);
        chk({o_init_req, o_init_mux_cfg}, 8);
        cyc_n(8);
        chk({o_init_req, o_init_mux_cfg}, 0);
        // second boot with the link supply late: reset must wait out the settle count
        i_rst = 1;
        i_link_ctrl_supply_good = 0;
        i_port_connected = 0;
        cyc_n(2);
        i_rst = 0;
        cyc_n(20);
        chk({o_link_ctrl_reset_line_n, o_flash_grant_link}, 0);
        i_link_ctrl_supply_good = 1;
        cyc_n(4);
        chk({o_link_ctrl_reset_line_n, o_flash_grant_link}, 0);
        cyc_n(4);
        chk({o_link_ctrl_reset_line_n, o_flash_grant_link}, 3);
        print_verdict;
    end
endmodule // shared_flash_boot_mux_ctrl_tb
`default_nettype wire
